// >>> tmz_defines.vh
`ifndef TMZ_DEFINES_VH
`define TMZ_DEFINES_VH

// ==========================================================================
// Register indices (byte address is four times the index)
`define TMZ_IDX_TIMER_COUNT   8'h01
`define TMZ_IDX_INT_CONTROL   8'h0B
`define TMZ_IDX_OPTION_CONFIG 8'h81
`define TMZ_IDX_PORT_C_DIR    8'h87

// ==========================================================================
// Reset values
`define TMZ_RST_TIMER_COUNT   8'h00
`define TMZ_RST_INT_CONTROL   8'h00
`define TMZ_RST_OPTION_CONFIG 8'hFF
`define TMZ_RST_PORT_C_DIR    8'hFF

// ==========================================================================
// Option register fields
`define TMZ_OPT_PULLUP        7
`define TMZ_OPT_SRC           5
`define TMZ_OPT_EDGE          4
`define TMZ_OPT_ASSIGN        3
`define TMZ_OPT_RATIO_MSB     2
`define TMZ_OPT_RATIO_LSB     0
`define TMZ_OPT_WR_MASK       8'hBF

// ==========================================================================
// Interrupt control fields
`define TMZ_INT_GLOBAL_EN     7
`define TMZ_INT_PERIPH_EN     6
`define TMZ_INT_OVF_EN        5
`define TMZ_INT_OVF_FLAG      2
`define TMZ_INT_WR_MASK       8'hE4

// ==========================================================================
// Phase clocks and timing
`define TMZ_PHASE_Q1          2'h0
`define TMZ_PHASE_Q2          2'h1
`define TMZ_PHASE_Q4          2'h3
`define TMZ_INHIBIT_CYCLES    2'h2
`define TMZ_COUNT_MAX         8'hFF

`endif

// >>> tmz_sync.v
`timescale 1ns/10ps
`default_nettype none

module tmz_sync (
  input  wire core_clk_i,
  input  wire resetn_i,
  input  wire sample_i,
  input  wire level_i,
  output wire rise_o
);

  // ==========================================================================
  // Level sampled on phase strobes, then edge detected
  reg       meta_q;
  reg       sync_q;
  reg       prev_q;
  reg       rise_q;
  reg [1:0] fill_q;

  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
      rise_q <= 1'b0;
      fill_q <= 2'h0;
    end else begin
      // No edge is reported until the chain holds three real samples
      rise_q <= sample_i & (fill_q == 2'h3) & sync_q & ~prev_q;
      if (sample_i) begin
        meta_q <= level_i;
        sync_q <= meta_q;
        prev_q <= sync_q;
        if (fill_q != 2'h3) begin
          fill_q <= fill_q + 2'h1;
        end
      end
    end
  end

  assign rise_o = rise_q;

endmodule // tmz_sync

`default_nettype wire

// >>> tmz_scaler.v
`timescale 1ns/10ps
`default_nettype none

module tmz_scaler (
  input  wire       core_clk_i,
  input  wire       resetn_i,
  input  wire       clear_i,
  input  wire       tick_i,
  input  wire [2:0] tap_sel_i,
  output wire       tap_o
);

  // ==========================================================================
  // Shared scaler counter, no software access
  reg [7:0] count_q;

  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      count_q <= 8'h00;
    end else if (clear_i) begin
      count_q <= 8'h00;
    end else if (tick_i) begin
      count_q <= count_q + 8'h01;
    end
  end

  // Each tap bit is a symmetrical square wave
  assign tap_o = count_q[tap_sel_i];

endmodule // tmz_scaler

`default_nettype wire

// >>> tmz_top.v
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "tmz_defines.vh"

module tmz_top (
  input  wire        core_clk_i,
  input  wire        resetn_i,
  input  wire [9:0]  paddr_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  input  wire        external_count_input_i,
  input  wire        watchdog_tick_i,
  input  wire        watchdog_clear_instruction_i,
  output wire        watchdog_timeout_o,
  output wire        timer_overflow_flag_o,
  output wire [7:0]  port_c_direction_o,
  output wire        port_c_pullup_control_o
);

  // ==========================================================================
  // Internal phase clocks Q1..Q4, one instruction cycle per four clocks
  reg  [1:0] phase_q;
  wire       q2_strobe;
  wire       q4_strobe;

  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      phase_q <= `TMZ_PHASE_Q1;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end

  assign q2_strobe = (phase_q == `TMZ_PHASE_Q2);
  assign q4_strobe = (phase_q == `TMZ_PHASE_Q4);

  // ==========================================================================
  // Register state
  reg  [7:0]  timer_count_q;
  reg  [7:0]  option_q;
  reg  [7:0]  int_control_q;
  reg  [7:0]  port_c_dir_q;
  reg  [31:0] prdata_q;
  reg         pslverr_q;

  wire        scaler_assign_bit;
  wire [2:0]  scale_ratio_field;
  wire        count_source_select;
  wire        count_edge_select;

  assign scaler_assign_bit   = option_q[`TMZ_OPT_ASSIGN];
  assign scale_ratio_field   = option_q[`TMZ_OPT_RATIO_MSB:`TMZ_OPT_RATIO_LSB];
  assign count_source_select = option_q[`TMZ_OPT_SRC];
  assign count_edge_select   = option_q[`TMZ_OPT_EDGE];

  // ==========================================================================
  // APB decode
  wire       apb_setup;
  wire       apb_access;
  wire       apb_write;
  wire       word_aligned;
  wire       hit_timer;
  wire       hit_int;
  wire       hit_option;
  wire       hit_portc;
  wire       map_hit;
  wire       timer_write;

  assign apb_setup    = psel_i & ~penable_i;
  assign apb_access   = psel_i & penable_i;
  assign apb_write    = apb_access & pwrite_i;
  assign word_aligned = (paddr_i[1:0] == 2'h0);
  assign hit_timer    = word_aligned & (paddr_i[9:2] == `TMZ_IDX_TIMER_COUNT);
  assign hit_int      = word_aligned & (paddr_i[9:2] == `TMZ_IDX_INT_CONTROL);
  assign hit_option   = word_aligned & (paddr_i[9:2] == `TMZ_IDX_OPTION_CONFIG);
  assign hit_portc    = word_aligned & (paddr_i[9:2] == `TMZ_IDX_PORT_C_DIR);
  assign map_hit      = hit_timer | hit_int | hit_option | hit_portc;
  assign timer_write  = apb_write & hit_timer;

  // Read data and error are captured in the setup cycle
  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (apb_setup) begin
      pslverr_q <= ~map_hit;
      if (pwrite_i || !map_hit) begin
        prdata_q <= 32'h0000_0000;
      end else if (hit_timer) begin
        prdata_q <= {24'h000000, timer_count_q};
      end else if (hit_int) begin
        prdata_q <= {24'h000000, int_control_q};
      end else if (hit_option) begin
        prdata_q <= {24'h000000, option_q};
      end else begin
        prdata_q <= {24'h000000, port_c_dir_q};
      end
    end
  end

  // Zero wait states: every access ends in its first access cycle
  assign prdata_o  = prdata_q;
  assign pready_o  = 1'b1;
  assign pslverr_o = apb_access & pslverr_q;

  // ==========================================================================
  // Option and port C direction registers
  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      option_q     <= `TMZ_RST_OPTION_CONFIG;
      port_c_dir_q <= `TMZ_RST_PORT_C_DIR;
    end else begin
      if (apb_write && hit_option) begin
        option_q <= (pwdata_i[7:0] & `TMZ_OPT_WR_MASK) | (option_q & ~`TMZ_OPT_WR_MASK);
      end
      if (apb_write && hit_portc) begin
        port_c_dir_q <= pwdata_i[7:0];
      end
    end
  end

  assign port_c_direction_o      = port_c_dir_q;
  assign port_c_pullup_control_o = option_q[`TMZ_OPT_PULLUP];

  // ==========================================================================
  // Watchdog base counter
  reg  [7:0] wdog_count_q;
  wire       wdog_base_ovf;

  // A clear wins over a tick in the same cycle
  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      wdog_count_q <= 8'h00;
    end else if (watchdog_clear_instruction_i) begin
      wdog_count_q <= 8'h00;
    end else if (watchdog_tick_i) begin
      wdog_count_q <= wdog_count_q + 8'h01;
    end
  end

  assign wdog_base_ovf = watchdog_tick_i & ~watchdog_clear_instruction_i
                         & (wdog_count_q == `TMZ_COUNT_MAX);

  // ==========================================================================
  // External input edge detection for the ripple-style prescaler
  reg  ext_prev_q;
  wire ext_edge;

  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      ext_prev_q <= 1'b0;
    end else begin
      ext_prev_q <= external_count_input_i;
    end
  end

  // Edge select high counts falling edges
  assign ext_edge = count_edge_select ? (ext_prev_q & ~external_count_input_i)
                                      : (~ext_prev_q & external_count_input_i);

  // ==========================================================================
  // Shared scaler
  wire       scaler_clear;
  wire       scaler_tick;
  wire [2:0] tap_sel;
  wire       scaler_tap;

  assign scaler_clear = scaler_assign_bit ? watchdog_clear_instruction_i
                                          : timer_write;
  assign scaler_tick  = scaler_assign_bit ? wdog_base_ovf
                        : (count_source_select ? ext_edge : q4_strobe);
  // Timer taps bit n for /2^(n+1); watchdog taps bit n-1 for /2^n
  assign tap_sel      = scaler_assign_bit ? (scale_ratio_field - 3'h1)
                                          : scale_ratio_field;

  tmz_scaler u_scaler (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .clear_i    (scaler_clear),
    .tick_i     (scaler_tick),
    .tap_sel_i  (tap_sel),
    .tap_o      (scaler_tap)
  );

  // ==========================================================================
  // Watchdog postscaler and timeout
  reg  tap_prev_q;
  reg  timeout_q;
  wire tap_restart;
  wire tap_fall;
  wire wdog_post;

  // A clear or a new ratio restarts the tap, so no false falling edge follows
  assign tap_restart = scaler_clear | (apb_write & hit_option);
  assign tap_fall    = tap_prev_q & ~scaler_tap & ~watchdog_clear_instruction_i;

  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      tap_prev_q <= 1'b0;
      timeout_q  <= 1'b0;
    end else begin
      tap_prev_q <= scaler_tap & ~tap_restart;
      timeout_q  <= scaler_assign_bit ? wdog_post : wdog_base_ovf;
    end
  end

  // Ratio zero passes the base overflow straight through
  assign wdog_post = (scale_ratio_field == 3'h0) ? wdog_base_ovf : tap_fall;
  assign watchdog_timeout_o = timeout_q;

  // ==========================================================================
  // Count source synchronisation
  wire sync_level;
  wire sync_rise;

  // A change of source or edge select may show one false edge; write the timer after it
  // Scaler output when timer-assigned, otherwise the raw pin
  assign sync_level = scaler_assign_bit ? (external_count_input_i ^ count_edge_select)
                                        : scaler_tap;

  tmz_sync u_sync (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .sample_i   (q2_strobe | q4_strobe),
    .level_i    (sync_level),
    .rise_o     (sync_rise)
  );

  // ==========================================================================
  // Timer increment and write inhibit
  reg  [1:0] inhibit_q;
  wire       inc_req;
  wire       inc_ok;
  wire       overflow;

  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      inhibit_q <= 2'h0;
    end else if (timer_write) begin
      inhibit_q <= `TMZ_INHIBIT_CYCLES;
    end else if (q4_strobe && inhibit_q != 2'h0) begin
      inhibit_q <= inhibit_q - 2'h1;
    end
  end

  // Internal unprescaled counts each instruction cycle directly
  assign inc_req  = (scaler_assign_bit && !count_source_select) ? q4_strobe
                                                                 : sync_rise;
  assign inc_ok   = inc_req & (inhibit_q == 2'h0) & ~timer_write;
  assign overflow = inc_ok & (timer_count_q == `TMZ_COUNT_MAX);

  // A software write wins over an increment in the same cycle
  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      timer_count_q <= `TMZ_RST_TIMER_COUNT;
    end else if (timer_write) begin
      timer_count_q <= pwdata_i[7:0];
    end else if (inc_ok) begin
      timer_count_q <= timer_count_q + 8'h01;
    end
  end

  // ==========================================================================
  // Interrupt control, overflow flag set wins over software clear
  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      int_control_q <= `TMZ_RST_INT_CONTROL;
    end else begin
      if (apb_write && hit_int) begin
        int_control_q <= pwdata_i[7:0] & `TMZ_INT_WR_MASK;
      end
      if (overflow) begin
        int_control_q[`TMZ_INT_OVF_FLAG] <= 1'b1;
      end
    end
  end

  assign timer_overflow_flag_o = int_control_q[`TMZ_INT_OVF_FLAG];

endmodule // tmz_top

`default_nettype wire

// >>> tmz_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Checker on the top-level ports
module tmz_assertions (
  input wire logic        core_clk_i,
  input wire logic        resetn_i,
  input wire logic [9:0]  paddr_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        external_count_input_i,
  input wire logic        watchdog_tick_i,
  input wire logic        watchdog_clear_instruction_i,
  input wire logic        watchdog_timeout_o,
  input wire logic        timer_overflow_flag_o,
  input wire logic [7:0]  port_c_direction_o,
  input wire logic        port_c_pullup_control_o
);
  logic dir_wr_q;
  logic opt_wr_q;
  // Marks the cycle after a write to direction or option
  always @(posedge core_clk_i) begin
    dir_wr_q <= psel_i && penable_i && pwrite_i && paddr_i == 10'h21C;
    opt_wr_q <= psel_i && penable_i && pwrite_i && paddr_i == 10'h204;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_wr(a);
    psel_i && penable_i && pwrite_i && paddr_i == a;
  endsequence
  sequence s_no_set;
    !$rose(timer_overflow_flag_o) [*8];
  endsequence
  a_ready_high: assert property (pready_o)
    else $error("ready low");
  a_err_access: assert property (pslverr_o |-> psel_i && penable_i)
    else $error("error outside access");
  a_unmapped_zero: assert property (psel_i && penable_i && !pwrite_i && pslverr_o |-> prdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_upper_zero: assert property (prdata_o[31:8] == 24'h0)
    else $error("upper read bits set");
  a_flag_sticky: assert property (timer_overflow_flag_o && !(pwrite_i && penable_i && paddr_i == 10'h02C)
    |=> timer_overflow_flag_o) else $error("flag lost");
  a_write_hold: assert property (s_wr(10'h004) |=> s_no_set ##1 !$rose(timer_overflow_flag_o))
    else $error("count after timer write");
  a_dir_write: assert property (!$stable(port_c_direction_o) |-> dir_wr_q)
    else $error("direction changed alone");
  a_pullup_write: assert property (!$stable(port_c_pullup_control_o) |-> opt_wr_q)
    else $error("pullup changed alone");
  a_wd_clear: assert property (watchdog_clear_instruction_i |=> ##1 !watchdog_timeout_o [*8])
    else $error("timeout after clear");
  a_wd_pulse: assert property (watchdog_timeout_o |=> !watchdog_timeout_o)
    else $error("timeout too long");
endmodule // tmz_assertions
`default_nettype wire

// >>> tmz_cnt_src.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Count pin source: square wave in frames, low between
module tmz_cnt_src (
  input  wire logic       core_clk_i,
  input  wire logic       run_i,
  input  wire logic [3:0] half_i,
  output var  logic       pin_o
);
  logic [3:0] cnt_q;
  always @(posedge core_clk_i) begin
    if (!run_i) begin
      cnt_q <= 4'h1;
      pin_o <= 1'b0;
    end else if (cnt_q >= half_i) begin
      cnt_q <= 4'h1;
      pin_o <= ~pin_o;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule // tmz_cnt_src
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Self-checking bench
module tb_top;
  logic        clk, rstn, psel, pen, pwr, run, tick, wclr, qe;
  logic [9:0]  addr;
  logic [31:0] wdata, q;
  logic [3:0]  half;
  wire logic [31:0] rdata;
  wire logic        rdy, serr, pin, wd_to, flag, pull;
  wire logic [7:0]  dir;
  int          err_total, n_tests, h, k, r, n;
  tmz_top i_dut (.core_clk_i(clk), .resetn_i(rstn), .paddr_i(addr), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .pwdata_i(wdata), .prdata_o(rdata), .pready_o(rdy), .pslverr_o(serr),
    .external_count_input_i(pin), .watchdog_tick_i(tick), .watchdog_clear_instruction_i(wclr),
    .watchdog_timeout_o(wd_to), .timer_overflow_flag_o(flag), .port_c_direction_o(dir),
    .port_c_pullup_control_o(pull));
  tmz_cnt_src i_src (.core_clk_i(clk), .run_i(run), .half_i(half), .pin_o(pin));
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    addr <= a;
    wdata <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    q = rdata;
    qe = serr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_rng(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
    n_tests++;
    if ($isunknown(g) || g < lo || g > hi) begin
      err_total++;
      $display("wrong value t=%0t got=%h exp=%h..%h", $time, g, lo, hi);
    end
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    xfer(1'b0, a, 8'h00);
    chk(q, e);
  endtask
  function automatic int exp_div(input int kk, input int rr);
    return (kk + (1 << rr)) >> (rr + 1);
  endfunction
  // Timer cleared, pin run for kk periods, count read back
  task automatic ext(input int hh, input int kk, input int e);
    cyc(12);
    xfer(1'b1, 10'h004, 8'h00);
    cyc(12);
    half <= hh[3:0];
    run <= 1'b1;
    cyc(2 * hh * kk);
    run <= 1'b0;
    cyc(12);
    rd(10'h004, e);
  endtask
  task automatic clr();
    @(posedge clk);
    wclr <= 1'b1;
    @(posedge clk);
    wclr <= 1'b0;
  endtask
  task automatic wdm(input logic [7:0] opt, input int e);
    clr();
    xfer(1'b1, 10'h004, 8'h00);
    xfer(1'b1, 10'h204, 8'h2F);
    clr();
    xfer(1'b1, 10'h204, opt);
    clr();
    n = 0;
    while (wd_to !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk_rng(n, e - 3, e + 3);
  endtask
  task automatic print_verdict();
    $display("errors %0d checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #2500000;
    err_total++;
    print_verdict();
  end
  initial begin
    {rstn, psel, pen, pwr, run, tick, wclr} = 7'h00;
    addr = 10'h000;
    wdata = 32'h0;
    half = 4'h2;
    err_total = 0;
    n_tests = 0;
    void'($urandom(66));
    cyc(6);
    rstn <= 1'b1;
    rd(10'h204, 32'hFF);
    rd(10'h02C, 32'h00);
    rd(10'h21C, 32'hFF);
    rd(10'h008, 32'h00);
    chk({31'h0, qe}, 32'h1);
    rd(10'h005, 32'h00);
    chk({31'h0, qe}, 32'h1);
    xfer(1'b1, 10'h21C, 8'h5A);
    @(negedge clk);
    chk({24'h0, dir}, 32'h5A);
    xfer(1'b1, 10'h204, 8'h68);
    rd(10'h204, 32'h68);
    chk({31'h0, pull}, 32'h0);
    for (int s = 0; s < 2; s++) begin
      h = 2 + $urandom % 4;
      k = 3 + $urandom % 10;
      xfer(1'b1, 10'h204, {3'h1, s[0], 4'h8});
      ext(h, k, k);
    end
    r = $urandom % 3;
    k = 4 + $urandom % 16;
    xfer(1'b1, 10'h204, {5'h04, r[2:0]});
    ext(2, k, exp_div(k, r));
    xfer(1'b1, 10'h204, 8'h08);
    xfer(1'b1, 10'h004, 8'h00);
    cyc(40);
    xfer(1'b0, 10'h004, 8'h00);
    chk_rng(q, 7, 11);
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, 10'h204, {5'h00, i[2:0]});
      xfer(1'b1, 10'h004, 8'h00);
      cyc(40 << i);
      xfer(1'b0, 10'h004, 8'h00);
      chk_rng(q, 3, 5);
    end
    xfer(1'b1, 10'h204, 8'h08);
    xfer(1'b1, 10'h004, 8'hFE);
    rd(10'h004, 32'hFE);
    cyc(30);
    @(negedge clk);
    chk({31'h0, flag}, 32'h1);
    cyc(20);
    @(negedge clk);
    chk({31'h0, flag}, 32'h1);
    xfer(1'b1, 10'h02C, 8'h00);
    @(negedge clk);
    chk({31'h0, flag}, 32'h0);
    xfer(1'b1, 10'h02C, 8'hFF);
    rd(10'h02C, 32'hE4);
    xfer(1'b1, 10'h02C, 8'h00);
    tick <= 1'b1;
    wdm(8'h08, 256);
    wdm(8'h0A, 1024);
    wdm(8'h00, 256);
    tick <= 1'b0;
    print_verdict();
  end
endmodule // tb_top
bind tmz_top tmz_assertions i_chk (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .paddr_i(paddr_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .external_count_input_i(external_count_input_i),
  .watchdog_tick_i(watchdog_tick_i), .watchdog_clear_instruction_i(watchdog_clear_instruction_i),
  .watchdog_timeout_o(watchdog_timeout_o), .timer_overflow_flag_o(timer_overflow_flag_o),
  .port_c_direction_o(port_c_direction_o), .port_c_pullup_control_o(port_c_pullup_control_o));
`default_nettype wire
